// >>> hdl/io_iso_ctrl.sv
// Notes on behaviour
// - Two 16-bit read/write registers, each assigned bit isolates one pin or group.
// - Unassigned bits always read zero and ignore writes.
// - A zero bit leaves its pins in normal buffer operation.
// - A one bit disables the input path and floats the output.
// - Bus register bit 6 isolates data pins 31 down to 16.
// - Bus register bit 5 isolates address pins 25 down to 19.
// - Bus register bit 4 isolates address pin 0.
// - Bus register bit 3 isolates the bus request pin.
// - Bus register bit 2 isolates the bus acknowledge pin.
// - Bus register bit 1 isolates the column strobe pin.
// - Bus register bit 0 isolates the row strobe; bits 15..7 unassigned.
// - Port register bits 11..8 isolate port F pins 3..0; 15..12 unused.
// - Port register bits 7..0 isolate port C pins 7..0 one to one.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
module io_iso_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire io_iso_pkg::axi_addr_t i_aw,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire io_iso_pkg::axi_wdata_t i_w,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire io_iso_pkg::axi_addr_t i_ar,
  output logic o_rvalid,
  input wire logic i_rready,
  output io_iso_pkg::axi_rdata_t o_r,
  input wire io_iso_pkg::pins_t i_func_out,
  input wire io_iso_pkg::pins_t i_func_oe,
  output io_iso_pkg::pins_t o_func_in,
  input wire io_iso_pkg::pins_t i_pad_in,
  output io_iso_pkg::pins_t o_pad_out,
  output io_iso_pkg::pins_t o_pad_oe
);
  import io_iso_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte strobes merge into the old value, then unassigned bits are dropped.
  function automatic logic [REG_W-1:0] merge_write(
    input logic [REG_W-1:0] old_val,
    input logic [DATA_W-1:0] data,
    input logic [STRB_W-1:0] strb,
    input logic [REG_W-1:0] impl
  );
    logic [REG_W-1:0] v;
    v = old_val;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v & impl;
  endfunction : merge_write

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == BUS_ISO_OFFSET) || (a == PORT_ISO_OFFSET) ||
           (a == PIN_LEVEL_LO_OFFSET) || (a == PIN_LEVEL_HI_OFFSET);
  endfunction : addr_known

  function automatic logic addr_writable(input logic [ADDR_W-1:0] a);
    return (a == BUS_ISO_OFFSET) || (a == PORT_ISO_OFFSET);
  endfunction : addr_writable

  //////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [REG_W-1:0] bus_iso_q;
  logic [REG_W-1:0] port_iso_q;
  pins_t iso_map;
  pins_t pad_sync;
  pins_t func_in;

  //////////////////////////////////////////////////////////////////////////
  // Write channel.

  logic aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  axi_wdata_t w_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_commit;

  // Address and data are latched in either order; the response
  // blocks both until it has been taken.
  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready = !w_held_q && !bvalid_q;
  assign wr_commit = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= i_aw.addr;
    end else if (wr_commit) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      w_held_q <= 1'b0;
      w_q <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held_q <= 1'b1;
      w_q <= i_w;
    end else if (wr_commit) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_writable(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  //////////////////////////////////////////////////////////////////////////
  // Isolation registers.

  // Both start cleared so every pin boots in normal operation.
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      bus_iso_q <= BUS_ISO_RESET;
    end else if (wr_commit && aw_addr_q == BUS_ISO_OFFSET) begin
      bus_iso_q <= merge_write(bus_iso_q, w_q.data, w_q.strb,
                               BUS_ISO_IMPL);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      port_iso_q <= PORT_ISO_RESET;
    end else if (wr_commit && aw_addr_q == PORT_ISO_OFFSET) begin
      port_iso_q <= merge_write(port_iso_q, w_q.data, w_q.strb,
                                PORT_ISO_IMPL);
    end
  end

  // Software is expected to write zeros into unused positions; the mask
  // above keeps a careless write harmless anyway.

  //////////////////////////////////////////////////////////////////////////
  // Expansion of register bits onto pin groups.

  always_comb begin
    iso_map = '0;
    iso_map.upper_data = {16{bus_iso_q[ISO_UPPER_DATA_BIT]}};
    iso_map.upper_addr = {7{bus_iso_q[ISO_UPPER_ADDR_BIT]}};
    iso_map.addr_lsb = bus_iso_q[ISO_ADDR_LSB_BIT];
    iso_map.bus_request_pin = bus_iso_q[ISO_BUS_REQUEST_BIT];
    iso_map.bus_ack = bus_iso_q[ISO_BUS_ACK_BIT];
    iso_map.col_strobe = bus_iso_q[ISO_COL_STROBE_BIT];
    iso_map.row_strobe = bus_iso_q[ISO_ROW_STROBE_BIT];
    iso_map.port_f = port_iso_q[ISO_PORTF_LSB +: 4];
    iso_map.port_c = port_iso_q[ISO_PORTC_LSB +: 8];
  end

  //////////////////////////////////////////////////////////////////////////
  // Pad side.

  // Pads are asynchronous to the bus clock, so their levels pass two
  // flops; functions that sample pads see two extra cycles of latency.
  pin_sync2 #(
    .WIDTH(PIN_W)
  ) u_pad_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async(i_pad_in),
    .o_sync(pad_sync)
  );

  // Gating is combinational from the register, so a committed write acts
  // on the pads in the very next cycle.
  pin_iso_gate #(
    .WIDTH(PIN_W)
  ) u_gate (
    .i_iso(iso_map),
    .i_func_out(i_func_out),
    .i_func_oe(i_func_oe),
    .i_pad_in(pad_sync),
    .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe),
    .o_func_in(func_in)
  );

  assign o_func_in = func_in;

  //////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic rvalid_q;
  axi_rdata_t r_q;
  logic [DATA_W-1:0] rd_data;

  assign o_arready = !rvalid_q;

  // The level words show what the functions actually receive, so an
  // isolated pin reads as zero here as well.
  always_comb begin
    rd_data = '0;
    case (i_ar.addr)
      BUS_ISO_OFFSET: rd_data[REG_W-1:0] = bus_iso_q & BUS_ISO_IMPL;
      PORT_ISO_OFFSET: rd_data[REG_W-1:0] = port_iso_q & PORT_ISO_IMPL;
      PIN_LEVEL_LO_OFFSET: rd_data = func_in[DATA_W-1:0];
      PIN_LEVEL_HI_OFFSET: rd_data[PIN_W-DATA_W-1:0] =
        func_in[PIN_W-1:DATA_W];
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rvalid_q <= 1'b0;
      r_q <= '0;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      r_q.data <= rd_data;
      r_q.resp <= addr_known(i_ar.addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_q;
  assign o_r = r_q;

endmodule : io_iso_ctrl
`default_nettype wire

// >>> hdl/io_iso_pkg.sv
`default_nettype none
package io_iso_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int REG_W = 16;

  localparam logic [ADDR_W-1:0] BUS_ISO_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] PORT_ISO_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_LO_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_HI_OFFSET = 8'h0c;

  localparam logic [REG_W-1:0] BUS_ISO_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PORT_ISO_RESET = 16'h0000;
  localparam logic [REG_W-1:0] BUS_ISO_IMPL = 16'h007f;
  localparam logic [REG_W-1:0] PORT_ISO_IMPL = 16'h0fff;

  localparam int ISO_UPPER_DATA_BIT = 6;
  localparam int ISO_UPPER_ADDR_BIT = 5;
  localparam int ISO_ADDR_LSB_BIT = 4;
  localparam int ISO_BUS_REQUEST_BIT = 3;
  localparam int ISO_BUS_ACK_BIT = 2;
  localparam int ISO_COL_STROBE_BIT = 1;
  localparam int ISO_ROW_STROBE_BIT = 0;
  localparam int ISO_PORTF_LSB = 8;
  localparam int ISO_PORTC_LSB = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] upper_data;
    logic [6:0] upper_addr;
    logic addr_lsb;
    logic bus_request_pin;
    logic bus_ack;
    logic col_strobe;
    logic row_strobe;
    logic [3:0] port_f;
    logic [7:0] port_c;
  } pins_t;

  localparam int PIN_W = $bits(pins_t);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [2:0] prot;
  } axi_addr_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } axi_wdata_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] resp;
  } axi_rdata_t;

endpackage : io_iso_pkg
`default_nettype wire

// >>> hdl/pin_sync2.sv
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : pin_sync2
`default_nettype wire

// >>> hdl/pin_iso_gate.sv
`default_nettype none
module pin_iso_gate #(
  parameter int WIDTH = 1
) (
  input wire logic [WIDTH-1:0] i_iso,
  input wire logic [WIDTH-1:0] i_func_out,
  input wire logic [WIDTH-1:0] i_func_oe,
  input wire logic [WIDTH-1:0] i_pad_in,
  output logic [WIDTH-1:0] o_pad_out,
  output logic [WIDTH-1:0] o_pad_oe,
  output logic [WIDTH-1:0] o_func_in
);

  // A clear bit passes function and pad unchanged.
  // A set bit kills the driver and the input path together.
  assign o_pad_oe = i_func_oe & ~i_iso;
  // The data line is parked low so an isolated pad shows no toggling.
  assign o_pad_out = i_func_out & ~i_iso;
  assign o_func_in = i_pad_in & ~i_iso;

endmodule : pin_iso_gate
`default_nettype wire

// >>> test/io_iso_ctrl_checker.sv
`default_nettype none
module io_iso_ctrl_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire io_iso_pkg::axi_rdata_t o_r,
  input wire io_iso_pkg::pins_t i_func_out,
  input wire io_iso_pkg::pins_t i_func_oe,
  input wire io_iso_pkg::pins_t o_pad_out,
  input wire io_iso_pkg::pins_t o_pad_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import io_iso_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  oe_gate_a: assert property ((o_pad_oe & ~i_func_oe) == '0)
    else $error("pad oe without core oe");
  out_gate_a: assert property ((o_pad_out & ~i_func_out) == '0)
    else $error("pad out without core out");
  start_norm_a: assert property ($rose(i_resetn) |->
    o_pad_oe == i_func_oe && o_pad_out == i_func_out)
    else $error("pads gated after reset");
  wr_resp_a: assert property (i_awvalid && o_awready && i_wvalid &&
    o_wready |-> ##[1:2] o_bvalid) else $error("no write response");
  rd_resp_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("no read response");
  b_hold_a: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  r_hold_a: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_r)) else $error("read response dropped");
  ar_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  aw_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while busy");
  err_zero_a: assert property (o_rvalid && o_r.resp == RESP_SLVERR
    |-> o_r.data == '0) else $error("error read not zero");
endmodule : io_iso_ctrl_checker
bind io_iso_ctrl io_iso_ctrl_checker chk (
  .i_sys_clk, .i_resetn, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid,
  .i_rready, .o_r, .i_func_out, .i_func_oe, .o_pad_out, .o_pad_oe
);
`default_nettype wire

// >>> test/test_io_iso_ctrl.sv
`default_nettype none
module test_io_iso_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import io_iso_pkg::*;
  logic i_sys_clk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0;
  logic i_bready = 0, i_arvalid = 0, i_rready = 0;
  axi_addr_t i_aw = '0, i_ar = '0;
  axi_wdata_t i_w = '0;
  pins_t i_func_out = '0, i_func_oe = '0, i_pad_in = '0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp;
  axi_rdata_t o_r;
  pins_t o_func_in, o_pad_out, o_pad_oe;
  int n_mismatch = 0, num_checks = 0;
  logic [15:0] rb = '0, rc = '0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  io_iso_ctrl dut (.i_sys_clk, .i_resetn, .i_awvalid, .o_awready, .i_aw,
    .i_wvalid, .o_wready, .i_w, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
    .o_arready, .i_ar, .o_rvalid, .i_rready, .o_r, .i_func_out, .i_func_oe,
    .o_func_in, .i_pad_in, .o_pad_out, .o_pad_oe);
  //////////////////////////////////////////////////////////////////////////
  function automatic pins_t mask_of(logic [15:0] b, logic [15:0] c);
    pins_t m;
    m.upper_data = {16{b[6]}};
    m.upper_addr = {7{b[5]}};
    m.addr_lsb = b[4];
    m.bus_request_pin = b[3];
    m.bus_ack = b[2];
    m.col_strobe = b[1];
    m.row_strobe = b[0];
    m.port_f = c[11:8];
    m.port_c = c[7:0];
    return m;
  endfunction : mask_of
  task automatic cmp(string nm, logic [39:0] e, logic [39:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // Handshakes are sampled at the falling edge, which avoids racing the
  // design's own updates at the rising edge.
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
                    logic [1:0] er);
    logic g, ta, tw;
    logic [1:0] rs;
    int n;
    g = 0;
    n = 0;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_aw <= {a, 3'h0};
    i_w <= {d, s};
    i_bready <= 0;
    while (!g) begin
      @(negedge i_sys_clk);
      g = o_bvalid && i_bready;
      rs = o_bresp;
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      @(posedge i_sys_clk);
      if (ta) i_awvalid <= 0;
      if (tw) i_wvalid <= 0;
      n++;
      if (n == 3) i_bready <= 1;
    end
    cmp("bresp", er, rs);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    logic g, ta;
    axi_rdata_t v;
    int n;
    g = 0;
    n = 0;
    i_arvalid <= 1;
    i_ar <= {a, 3'h0};
    i_rready <= 0;
    while (!g) begin
      @(negedge i_sys_clk);
      g = o_rvalid && i_rready;
      v = o_r;
      ta = i_arvalid && o_arready;
      @(posedge i_sys_clk);
      if (ta) i_arvalid <= 0;
      n++;
      if (n == 3) i_rready <= 1;
    end
    cmp("rdata", ed, v.data);
    cmp("rresp", er, v.resp);
  endtask : rd
  task automatic put(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    logic [15:0] bm;
    logic ok;
    bm = {{8{s[1]}}, {8{s[0]}}};
    ok = a == BUS_ISO_OFFSET || a == PORT_ISO_OFFSET;
    if (a == BUS_ISO_OFFSET) rb = ((rb & ~bm) | (d[15:0] & bm)) & BUS_ISO_IMPL;
    if (a == PORT_ISO_OFFSET) begin
      rc = ((rc & ~bm) | (d[15:0] & bm)) & PORT_ISO_IMPL;
    end
    wr(a, d, s, ok ? RESP_OKAY : RESP_SLVERR);
    rd(a, a == BUS_ISO_OFFSET ? {16'h0, rb} : a == PORT_ISO_OFFSET ?
       {16'h0, rc} : 32'h0, ok ? RESP_OKAY : RESP_SLVERR);
  endtask : put
  task automatic pins;
    logic [63:0] v;
    pins_t m, e;
    v = {$urandom, $urandom};
    i_func_out <= v[39:0];
    v = {$urandom, $urandom};
    i_func_oe <= v[39:0];
    v = {$urandom, $urandom};
    i_pad_in <= v[39:0];
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    m = mask_of(rb, rc);
    e = i_pad_in & ~m;
    cmp("pad_oe", i_func_oe & ~m, o_pad_oe);
    cmp("pad_out", i_func_out & ~m, o_pad_out);
    cmp("func_in", e, o_func_in);
    @(posedge i_sys_clk);
    rd(PIN_LEVEL_LO_OFFSET, e[31:0], RESP_OKAY);
    rd(PIN_LEVEL_HI_OFFSET, {24'h0, e[39:32]}, RESP_OKAY);
  endtask : pins
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int r;
    logic [7:0] a;
    void'($urandom(18));
    repeat (20) @(posedge i_sys_clk);
    i_resetn <= 1;
    for (int k = 0; k < 2; k++) begin
      rd(BUS_ISO_OFFSET, 32'h0, RESP_OKAY);
      rd(PORT_ISO_OFFSET, 32'h0, RESP_OKAY);
      pins;
      for (int b = 0; b < 32; b++) begin
        put(b < 16 ? BUS_ISO_OFFSET : PORT_ISO_OFFSET,
            32'h1 << b[3:0], 4'hf);
        pins;
      end
      put(BUS_ISO_OFFSET, 32'hffffffff, 4'hf);
      put(PORT_ISO_OFFSET, 32'hffffffff, 4'hf);
      pins;
      // A well-behaved writer leaves every unassigned position at zero.
      put(BUS_ISO_OFFSET, {16'h0, BUS_ISO_IMPL}, 4'h3);
      put(PORT_ISO_OFFSET, {16'h0, PORT_ISO_IMPL}, 4'h3);
      pins;
      repeat (25) begin
        r = $urandom % 3;
        a = r == 2 ? 8'h20 : 8'(r << 2);
        put(a, $urandom, 4'($urandom));
        pins;
      end
      i_resetn <= 0;
      repeat (3) @(posedge i_sys_clk);
      i_resetn <= 1;
      rb = '0;
      rc = '0;
    end
    complete_run;
  end
  initial begin
    repeat (30000) @(posedge i_sys_clk);
    n_mismatch++;
    complete_run;
  end
endmodule : test_io_iso_ctrl
`default_nettype wire
